/* File: mrc_device.sv */
`timescale 1ns/1ns
`default_nettype none
module mrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = mrc_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [AW:0] count_ff, nxt_count;
  logic full_ff, empty_ff, nxt_full, nxt_empty;
  logic push, pop;

  assign in_ready = !full_ff;
  assign out_valid = !empty_ff;
  assign out_data = mem[rd_ptr_ff];

  always_comb
  begin
    push = in_valid && !full_ff;
    pop = out_ready && !empty_ff;
    nxt_wr_ptr = push ? ((wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? ((rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count = count_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    nxt_full = (nxt_count == (AW + 1)'(DEPTH));
    nxt_empty = (nxt_count == '0);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
    end
    else
    begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff <= nxt_count;
      full_ff <= nxt_full;
      empty_ff <= nxt_empty;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_ff] <= in_data;
    end
  end
endmodule : mrc_fifo

module mrc_device #(
  parameter logic [7:0] DEV_ADDR = 8'h01,
  parameter int NREG = 16,
  parameter int SILENCE_CYC = mrc_pkg::SILENCE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  mrc_link_if.dev lnk,
  input wire logic usr_wr_en,
  input wire logic [$clog2(NREG)-1:0] usr_wr_idx,
  input wire logic [15:0] usr_wr_data,
  input wire logic [$clog2(NREG)-1:0] usr_rd_idx,
  output logic [15:0] usr_rd_data,
  output logic crc_err,
  output logic frame_ok,
  output logic func_bad
);
  localparam int IW = $clog2(NREG);
  localparam int CW = $clog2(SILENCE_CYC + 1);
  localparam logic [CW-1:0] SIL_LAST = CW'(SILENCE_CYC - 1);

  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_SEND = 2'b01,
    ST_CRC_LO = 2'b10,
    ST_CRC_HI = 2'b11
  } mrc_dev_state_e;

  mrc_dev_state_e state_ff, nxt_state;
  logic [7:0] rx_buf [mrc_pkg::RX_BUF_DEPTH];
  logic [15:0] regs [NREG];
  logic [3:0] rx_cnt_ff, nxt_rx_cnt;
  logic [CW-1:0] idle_ff, nxt_idle;
  logic [15:0] crc_run_ff, crc_p1_ff, crc_p2_ff, nxt_crc_run, nxt_crc_p1, nxt_crc_p2;
  logic [15:0] crc_tx_ff, nxt_crc_tx;
  logic [9:0] tx_idx_ff, tx_len_ff, nxt_tx_idx, nxt_tx_len;
  logic rx_rdy_ff, nxt_rx_rdy;
  logic crc_err_ff, frame_ok_ff, func_bad_ff, nxt_crc_err, nxt_frame_ok, nxt_func_bad;
  logic [15:0] usr_rd_data_ff;
  logic byte_in, reg_we, push_valid, push_ready, len_ok, for_me;
  logic [7:0] push_data, tx_byte;
  logic [9:0] k;
  logic [IW-1:0] rd_idx;
  logic [15:0] rd_word;

  assign lnk.m2d_ready = rx_rdy_ff;
  assign crc_err = crc_err_ff;
  assign frame_ok = frame_ok_ff;
  assign func_bad = func_bad_ff;
  assign usr_rd_data = usr_rd_data_ff;

  // Reply is queued so the link may stall for up to FIFO_DEPTH bytes without stalling decode
  mrc_fifo #(.WIDTH(8), .DEPTH(mrc_pkg::FIFO_DEPTH)) u_tx_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(lnk.d2m_valid),
    .out_data(lnk.d2m_data),
    .out_ready(lnk.d2m_ready)
  );

  always_comb
  begin
    k = tx_idx_ff - 10'(mrc_pkg::RSP_HDR_LEN);
    rd_idx = rx_buf[3][IW-1:0] + IW'(k[9:1]);
    rd_word = regs[rd_idx];
    tx_byte = rx_buf[tx_idx_ff[2:0]];
    if (rx_buf[1] == mrc_pkg::FUNC_RD_MULTI)
    begin
      if (tx_idx_ff == 10'd2)
      begin
        tx_byte = {rx_buf[5][6:0], 1'b0};
      end
      else if (tx_idx_ff >= 10'(mrc_pkg::RSP_HDR_LEN))
      begin
        tx_byte = k[0] ? rd_word[7:0] : rd_word[15:8];
      end
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_idle = idle_ff;
    nxt_crc_run = crc_run_ff;
    nxt_crc_p1 = crc_p1_ff;
    nxt_crc_p2 = crc_p2_ff;
    nxt_crc_tx = crc_tx_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_tx_len = tx_len_ff;
    nxt_crc_err = 1'b0;
    nxt_frame_ok = 1'b0;
    nxt_func_bad = 1'b0;
    reg_we = 1'b0;
    push_valid = 1'b0;
    push_data = 8'h00;
    byte_in = lnk.m2d_valid && rx_rdy_ff;
    len_ok = (rx_cnt_ff >= 4'd4) && (rx_cnt_ff <= 4'(mrc_pkg::RX_BUF_DEPTH));
    for_me = (rx_buf[0] == DEV_ADDR) || (rx_buf[0] == mrc_pkg::ADDR_BCAST);
    unique case (state_ff)
      ST_RX:
      begin
        if (byte_in)
        begin
          nxt_rx_cnt = (rx_cnt_ff == 4'd9) ? rx_cnt_ff : rx_cnt_ff + 4'd1;
          nxt_crc_p2 = crc_p1_ff;
          nxt_crc_p1 = crc_run_ff;
          nxt_crc_run = mrc_pkg::crc_byte(crc_run_ff, lnk.m2d_data);
          nxt_idle = '0;
        end
        else if (idle_ff != SIL_LAST)
        begin
          nxt_idle = idle_ff + 1'b1;
        end
        else if (rx_cnt_ff != 4'd0)
        begin
          // Silence closes the frame; oversize frames fail the length test
          nxt_rx_cnt = 4'd0;
          nxt_crc_run = mrc_pkg::CRC_PRESET;
          nxt_crc_p1 = mrc_pkg::CRC_PRESET;
          nxt_crc_p2 = mrc_pkg::CRC_PRESET;
          if (!len_ok || crc_p2_ff != {rx_buf[3'(rx_cnt_ff - 4'd1)], rx_buf[3'(rx_cnt_ff - 4'd2)]})
          begin
            nxt_crc_err = 1'b1;
          end
          else if (for_me)
          begin
            nxt_frame_ok = 1'b1;
            nxt_tx_idx = '0;
            nxt_crc_tx = mrc_pkg::CRC_PRESET;
            if (rx_buf[1] == mrc_pkg::FUNC_RD_MULTI && rx_buf[0] != mrc_pkg::ADDR_BCAST)
            begin
              nxt_tx_len = 10'(mrc_pkg::RSP_HDR_LEN) + {1'b0, rx_buf[5], 1'b0};
              nxt_state = ST_SEND;
            end
            else if (rx_buf[1] == mrc_pkg::FUNC_WR_ONE)
            begin
              reg_we = 1'b1;
              nxt_tx_len = 10'(mrc_pkg::REQ_BODY_LEN);
              nxt_state = (rx_buf[0] == mrc_pkg::ADDR_BCAST) ? ST_RX : ST_SEND;
            end
            else if (rx_buf[1] != mrc_pkg::FUNC_RD_MULTI)
            begin
              // Multi-register write needs more buffer than kept here
              nxt_func_bad = 1'b1;
            end
          end
        end
      end
      ST_SEND:
      begin
        if (tx_len_ff == 10'd0)
        begin
          nxt_state = ST_CRC_LO;
        end
        else
        begin
          push_valid = 1'b1;
          push_data = tx_byte;
          if (push_ready)
          begin
            nxt_crc_tx = mrc_pkg::crc_byte(crc_tx_ff, tx_byte);
            nxt_tx_idx = tx_idx_ff + 10'd1;
            if (tx_idx_ff == tx_len_ff - 10'd1)
            begin
              nxt_state = ST_CRC_LO;
            end
          end
        end
      end
      ST_CRC_LO:
      begin
        push_valid = 1'b1;
        push_data = crc_tx_ff[7:0];
        if (push_ready)
        begin
          nxt_state = ST_CRC_HI;
        end
      end
      ST_CRC_HI:
      begin
        push_valid = 1'b1;
        push_data = crc_tx_ff[15:8];
        if (push_ready)
        begin
          nxt_state = ST_RX;
          nxt_idle = '0;
        end
      end
    endcase
    nxt_rx_rdy = (nxt_state == ST_RX);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_RX;
      rx_cnt_ff <= 4'd0;
      idle_ff <= '0;
      crc_run_ff <= mrc_pkg::CRC_PRESET;
      crc_p1_ff <= mrc_pkg::CRC_PRESET;
      crc_p2_ff <= mrc_pkg::CRC_PRESET;
      crc_tx_ff <= mrc_pkg::CRC_PRESET;
      tx_idx_ff <= '0;
      tx_len_ff <= '0;
      rx_rdy_ff <= 1'b0;
      crc_err_ff <= 1'b0;
      frame_ok_ff <= 1'b0;
      func_bad_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rx_cnt_ff <= nxt_rx_cnt;
      idle_ff <= nxt_idle;
      crc_run_ff <= nxt_crc_run;
      crc_p1_ff <= nxt_crc_p1;
      crc_p2_ff <= nxt_crc_p2;
      crc_tx_ff <= nxt_crc_tx;
      tx_idx_ff <= nxt_tx_idx;
      tx_len_ff <= nxt_tx_len;
      rx_rdy_ff <= nxt_rx_rdy;
      crc_err_ff <= nxt_crc_err;
      frame_ok_ff <= nxt_frame_ok;
      func_bad_ff <= nxt_func_bad;
    end
  end

  // Link write wins over a same-cycle user write
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NREG; i++)
      begin
        regs[i] <= 16'h0000;
      end
      for (int i = 0; i < mrc_pkg::RX_BUF_DEPTH; i++)
      begin
        rx_buf[i] <= 8'h00;
      end
      usr_rd_data_ff <= 16'h0000;
    end
    else
    begin
      if (reg_we)
      begin
        regs[rx_buf[3][IW-1:0]] <= {rx_buf[4], rx_buf[5]};
      end
      else if (usr_wr_en)
      begin
        regs[usr_wr_idx] <= usr_wr_data;
      end
      if (byte_in && rx_cnt_ff < 4'(mrc_pkg::RX_BUF_DEPTH))
      begin
        rx_buf[rx_cnt_ff[2:0]] <= lnk.m2d_data;
      end
      usr_rd_data_ff <= regs[usr_rd_idx];
    end
  end
endmodule : mrc_device
`default_nettype wire

/* File: mrc_link_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module mrc_link_checker #(
  parameter int SILENCE_CYC = 20
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic m2d_valid,
  input wire logic [7:0] m2d_data,
  input wire logic m2d_ready,
  input wire logic d2m_valid,
  input wire logic [7:0] d2m_data,
  input wire logic d2m_ready
);
  logic mt, dt, idle;
  logic [7:0] mc_ff, nxt_mc, dc_ff, nxt_dc, ad_ff, nxt_ad, cl_ff, nxt_cl, bc_ff, nxt_bc;
  logic [15:0] mcrc_ff, nxt_mcrc, dcrc_ff, nxt_dcrc, gap_ff, nxt_gap;
  function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ({1'b0, r[15:1]} ^ 16'ha001) : {1'b0, r[15:1]};
    end
    return r;
  endfunction : fold
  assign mt = m2d_valid && m2d_ready;
  assign dt = d2m_valid && d2m_ready;
  // Frames are split on silence, a little before the receiver would close them
  assign idle = !mt && !dt && gap_ff == 16'(SILENCE_CYC - 2);
  always_comb
  begin
    nxt_gap = (mt || dt) ? 16'h0 : gap_ff + {15'h0, gap_ff != 16'hffff};
    nxt_mc = idle ? 8'h0 : mc_ff + {7'h0, mt};
    nxt_dc = idle ? 8'h0 : dc_ff + {7'h0, dt};
    nxt_mcrc = idle ? 16'hffff : (mt && mc_ff < 8'h6) ? fold(mcrc_ff, m2d_data) : mcrc_ff;
    nxt_dcrc = idle ? 16'hffff :
      (dt && (dc_ff < 8'h3 || dc_ff < bc_ff + 8'h3)) ? fold(dcrc_ff, d2m_data) : dcrc_ff;
    nxt_ad = (mt && mc_ff == 8'h0) ? m2d_data : ad_ff;
    nxt_cl = (mt && mc_ff == 8'h5) ? m2d_data : cl_ff;
    nxt_bc = (dt && dc_ff == 8'h2) ? d2m_data : bc_ff;
  end
  always_ff @(posedge core_clk)
  begin
    gap_ff <= reset_n ? nxt_gap : 16'h0;
    mc_ff <= reset_n ? nxt_mc : 8'h0;
    dc_ff <= reset_n ? nxt_dc : 8'h0;
    mcrc_ff <= reset_n ? nxt_mcrc : 16'hffff;
    dcrc_ff <= reset_n ? nxt_dcrc : 16'hffff;
    ad_ff <= nxt_ad;
    cl_ff <= nxt_cl;
    bc_ff <= nxt_bc;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  AST_REQ_ADDR: assert property (mt && mc_ff == 8'h0 |-> m2d_data <= 8'hfe)
    else $error("request address out of range");
  AST_REQ_FUNC: assert property (mt && mc_ff == 8'h1 |-> m2d_data == 8'h03)
    else $error("request function wrong");
  AST_REQ_LEN: assert property (mt |-> mc_ff < 8'h8)
    else $error("request longer than eight bytes");
  AST_REQ_CRC: assert property (mt && mc_ff == 8'h6 |-> m2d_data == mcrc_ff[7:0]
    ##1 (mt && m2d_data == mcrc_ff[15:8]))
    else $error("request checksum wrong");
  AST_RSP_ECHO: assert property (dt && dc_ff == 8'h0 |-> d2m_data == ad_ff)
    else $error("reply address not echoed");
  AST_RSP_BCNT: assert property (dt && dc_ff == 8'h2
    |-> d2m_data == {cl_ff[6:0], 1'b0})
    else $error("reply byte count wrong");
  AST_RSP_CRC: assert property (dt && dc_ff >= 8'h3
    && dc_ff - bc_ff - 8'h3 < 8'h2
    |-> d2m_data == (dc_ff == bc_ff + 8'h3 ? dcrc_ff[7:0] : dcrc_ff[15:8]))
    else $error("reply checksum wrong");
  AST_BCAST_QUIET: assert property (mt && mc_ff == 8'h7 && ad_ff == 8'h00
    |=> !d2m_valid [*8])
    else $error("broadcast answered");
  AST_RSP_GAP: assert property (dt && dc_ff == 8'h0 |-> gap_ff >= SILENCE_CYC - 1)
    else $error("reply before line silence");
endmodule : mrc_link_checker
`default_nettype wire

/* File: mrc_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface mrc_link_if;
  logic m2d_valid;
  logic [7:0] m2d_data;
  logic m2d_ready;
  logic d2m_valid;
  logic [7:0] d2m_data;
  logic d2m_ready;
  modport dev (input m2d_valid, input m2d_data, output m2d_ready,
               output d2m_valid, output d2m_data, input d2m_ready);
  modport mst (output m2d_valid, output m2d_data, input m2d_ready,
               input d2m_valid, input d2m_data, output d2m_ready);
endinterface : mrc_link_if
`default_nettype wire

/* File: mrc_master.sv */
`timescale 1ns/1ns
`default_nettype none
module mrc_master #(
  parameter int SILENCE_CYC = mrc_pkg::SILENCE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  mrc_link_if.mst lnk,
  input wire logic req_valid,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_start,
  input wire logic [15:0] req_count,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic done,
  output logic crc_err
);
  localparam int CW = $clog2(SILENCE_CYC + 1);
  localparam logic [CW-1:0] SIL_LAST = CW'(SILENCE_CYC - 1);

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_SEND = 2'b01,
    MS_WAIT = 2'b10
  } mrc_mst_state_e;

  mrc_mst_state_e state_ff, nxt_state;
  logic [7:0] addr_ff, nxt_addr;
  logic [15:0] start_ff, count_ff, nxt_start, nxt_count;
  logic [3:0] idx_ff, nxt_idx;
  logic [15:0] crc_ff, nxt_crc, crc_p1_ff, crc_p2_ff, nxt_crc_p1, nxt_crc_p2;
  logic [7:0] data_ff, nxt_data, last_ff, prev_ff, nxt_last, nxt_prev, hi_ff, nxt_hi;
  logic valid_ff, nxt_valid, rdy_ff, nxt_rdy, req_ready_ff, nxt_req_ready;
  logic [16:0] rcnt_ff, nxt_rcnt, wend;
  logic [CW-1:0] idle_ff, nxt_idle;
  logic rsp_valid_ff, done_ff, crc_err_ff, nxt_rsp_valid, nxt_done, nxt_crc_err;
  logic [15:0] rsp_data_ff, nxt_rsp_data;
  logic [7:0] body;
  logic byte_in;

  assign lnk.m2d_valid = valid_ff;
  assign lnk.m2d_data = data_ff;
  assign lnk.d2m_ready = rdy_ff;
  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign done = done_ff;
  assign crc_err = crc_err_ff;

  always_comb
  begin
    unique case (idx_ff)
      4'd1: body = mrc_pkg::FUNC_RD_MULTI;
      4'd2: body = start_ff[15:8];
      4'd3: body = start_ff[7:0];
      4'd4: body = count_ff[15:8];
      default: body = count_ff[7:0];
    endcase
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_start = start_ff;
    nxt_count = count_ff;
    nxt_idx = idx_ff;
    nxt_crc = crc_ff;
    nxt_crc_p1 = crc_p1_ff;
    nxt_crc_p2 = crc_p2_ff;
    nxt_data = data_ff;
    nxt_valid = valid_ff;
    nxt_last = last_ff;
    nxt_prev = prev_ff;
    nxt_hi = hi_ff;
    nxt_rcnt = rcnt_ff;
    nxt_idle = idle_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    nxt_done = 1'b0;
    nxt_crc_err = 1'b0;
    byte_in = lnk.d2m_valid && rdy_ff;
    wend = 17'(mrc_pkg::RSP_HDR_LEN) + {count_ff, 1'b0};
    unique case (state_ff)
      MS_IDLE:
      begin
        if (req_valid && req_ready_ff)
        begin
          nxt_addr = req_addr;
          nxt_start = req_start;
          nxt_count = req_count;
          nxt_data = req_addr;
          nxt_valid = 1'b1;
          nxt_crc = mrc_pkg::crc_byte(mrc_pkg::CRC_PRESET, req_addr);
          nxt_idx = 4'd1;
          nxt_state = MS_SEND;
        end
      end
      MS_SEND:
      begin
        if (lnk.m2d_ready)
        begin
          nxt_idx = idx_ff + 4'd1;
          if (idx_ff < 4'(mrc_pkg::REQ_BODY_LEN))
          begin
            nxt_data = body;
            nxt_crc = mrc_pkg::crc_byte(crc_ff, body);
          end
          else if (idx_ff == 4'(mrc_pkg::REQ_BODY_LEN))
          begin
            nxt_data = crc_ff[7:0];
          end
          else if (idx_ff == 4'(mrc_pkg::REQ_BODY_LEN + 1))
          begin
            nxt_data = crc_ff[15:8];
          end
          else
          begin
            // Nobody answers a broadcast
            nxt_valid = 1'b0;
            nxt_idle = '0;
            nxt_rcnt = '0;
            nxt_crc = mrc_pkg::CRC_PRESET;
            nxt_crc_p1 = mrc_pkg::CRC_PRESET;
            nxt_crc_p2 = mrc_pkg::CRC_PRESET;
            nxt_done = (addr_ff == mrc_pkg::ADDR_BCAST);
            nxt_state = (addr_ff == mrc_pkg::ADDR_BCAST) ? MS_IDLE : MS_WAIT;
          end
        end
      end
      MS_WAIT:
      begin
        if (byte_in)
        begin
          nxt_rcnt = (rcnt_ff == 17'h1ffff) ? rcnt_ff : rcnt_ff + 17'd1;
          nxt_crc_p2 = crc_p1_ff;
          nxt_crc_p1 = crc_ff;
          nxt_crc = mrc_pkg::crc_byte(crc_ff, lnk.d2m_data);
          nxt_prev = last_ff;
          nxt_last = lnk.d2m_data;
          nxt_idle = '0;
          if (rcnt_ff >= 17'(mrc_pkg::RSP_HDR_LEN) && rcnt_ff < wend)
          begin
            if (rcnt_ff[0])
            begin
              nxt_hi = lnk.d2m_data;
            end
            else
            begin
              nxt_rsp_valid = 1'b1;
              nxt_rsp_data = {hi_ff, lnk.d2m_data};
            end
          end
        end
        else if (idle_ff != SIL_LAST)
        begin
          nxt_idle = idle_ff + 1'b1;
        end
        else if (rcnt_ff != '0)
        begin
          nxt_state = MS_IDLE;
          nxt_done = 1'b1;
          nxt_crc_err = (rcnt_ff < 17'd4) || (crc_p2_ff != {last_ff, prev_ff});
        end
      end
      default:
      begin
        nxt_state = MS_IDLE;
      end
    endcase
    nxt_rdy = (nxt_state == MS_WAIT);
    nxt_req_ready = (nxt_state == MS_IDLE);
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= MS_IDLE;
      addr_ff <= 8'h00;
      start_ff <= 16'h0000;
      count_ff <= 16'h0000;
      idx_ff <= 4'd0;
      crc_ff <= mrc_pkg::CRC_PRESET;
      crc_p1_ff <= mrc_pkg::CRC_PRESET;
      crc_p2_ff <= mrc_pkg::CRC_PRESET;
      data_ff <= 8'h00;
      valid_ff <= 1'b0;
      last_ff <= 8'h00;
      prev_ff <= 8'h00;
      hi_ff <= 8'h00;
      rcnt_ff <= '0;
      idle_ff <= '0;
      rdy_ff <= 1'b0;
      req_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= 16'h0000;
      done_ff <= 1'b0;
      crc_err_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      start_ff <= nxt_start;
      count_ff <= nxt_count;
      idx_ff <= nxt_idx;
      crc_ff <= nxt_crc;
      crc_p1_ff <= nxt_crc_p1;
      crc_p2_ff <= nxt_crc_p2;
      data_ff <= nxt_data;
      valid_ff <= nxt_valid;
      last_ff <= nxt_last;
      prev_ff <= nxt_prev;
      hi_ff <= nxt_hi;
      rcnt_ff <= nxt_rcnt;
      idle_ff <= nxt_idle;
      rdy_ff <= nxt_rdy;
      req_ready_ff <= nxt_req_ready;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      done_ff <= nxt_done;
      crc_err_ff <= nxt_crc_err;
    end
  end
endmodule : mrc_master
`default_nettype wire

/* File: mrc_pkg.sv */
`default_nettype none
package mrc_pkg;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX = 8'hfe;
  localparam logic [7:0] FUNC_RD_MULTI = 8'h03;
  localparam logic [7:0] FUNC_WR_ONE = 8'h06;
  localparam logic [7:0] FUNC_WR_MULTI = 8'h10;
  localparam int REQ_BODY_LEN = 6;
  localparam int RSP_HDR_LEN = 3;
  localparam int RX_BUF_DEPTH = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int BITS_PER_BYTE = 8;
  localparam int CLK_MHZ = 100;
  localparam int SILENCE_US = 2000;
  localparam int SILENCE_CYC = SILENCE_US * CLK_MHZ;

  function automatic logic [15:0] crc_byte(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    logic lsb;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < BITS_PER_BYTE; i++)
    begin
      lsb = c[0];
      c = {1'b0, c[15:1]};
      if (lsb)
      begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc_byte
endpackage : mrc_pkg
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int SIL = 20;
  typedef logic [7:0] mrc_bytes_t [$];
  typedef struct packed {
    logic [7:0] adr;
    logic [15:0] st;
    logic [15:0] cnt;
    logic [15:0] w0;
    logic [15:0] w1;
  } mrc_row_s;
  mrc_row_s rows [4] = '{
    '{8'h01, 16'h2102, 16'h0002, 16'h1770, 16'h0000},
    '{8'h01, 16'h000e, 16'h0002, 16'h5a3c, 16'hffff},
    '{8'h01, 16'h0005, 16'h0001, 16'h8001, 16'h0000},
    '{8'h00, 16'h0003, 16'h0001, 16'h0000, 16'h0000}};
  logic core_clk, reset_n, req_valid, req_ready, rsp_valid, done, m_err, wr_en;
  logic [7:0] req_addr;
  logic [15:0] req_start, req_count, rsp_data, wr_data, rd_a, rd_b;
  logic [3:0] wr_idx, rd_idx;
  logic [2:0] f;
  wire [2:0] fa, fb;
  int errors, num_checks, cyc, oks, n, k0;
  mrc_bytes_t rx, fr;
  mrc_link_if link();
  mrc_link_if link_b();
  mrc_master #(.SILENCE_CYC(SIL)) mrc_master_inst (.core_clk(core_clk), .reset_n(reset_n),
    .lnk(link), .req_valid(req_valid), .req_addr(req_addr), .req_start(req_start),
    .req_count(req_count), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .done(done), .crc_err(m_err));
  mrc_device #(.SILENCE_CYC(SIL)) mrc_device_inst (.core_clk(core_clk), .reset_n(reset_n),
    .lnk(link), .usr_wr_en(wr_en), .usr_wr_idx(wr_idx), .usr_wr_data(wr_data),
    .usr_rd_idx(rd_idx), .usr_rd_data(rd_a), .crc_err(fa[2]), .frame_ok(fa[1]), .func_bad(fa[0]));
  mrc_device #(.SILENCE_CYC(SIL)) mrc_device_inst2 (.core_clk(core_clk), .reset_n(reset_n),
    .lnk(link_b), .usr_wr_en(wr_en), .usr_wr_idx(wr_idx), .usr_wr_data(wr_data),
    .usr_rd_idx(rd_idx), .usr_rd_data(rd_b), .crc_err(fb[2]), .frame_ok(fb[1]), .func_bad(fb[0]));
  mrc_link_checker #(.SILENCE_CYC(SIL)) mrc_link_checker_inst (.core_clk(core_clk),
    .reset_n(reset_n), .m2d_valid(link.m2d_valid), .m2d_data(link.m2d_data),
    .m2d_ready(link.m2d_ready), .d2m_valid(link.d2m_valid), .d2m_data(link.d2m_data),
    .d2m_ready(link.d2m_ready));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      errors++;
      results();
    end
  end
  always @(negedge core_clk)
  begin
    if (fa[1] === 1'b1) oks++;
    // Bad-frame pulses on the master's link spoil the frame count
    if (fa[2] !== 1'b0 || fa[0] !== 1'b0) oks += 16;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  function automatic mrc_bytes_t with_crc(input mrc_bytes_t b);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
      begin
        c = c[0] ? ({1'b0, c[15:1]} ^ 16'ha001) : {1'b0, c[15:1]};
      end
    end
    return {b, c[7:0], c[15:8]};
  endfunction : with_crc
  task automatic wr_reg(input logic [3:0] idx, input logic [15:0] val);
    wr_en = 1'b1;
    wr_idx = idx;
    wr_data = val;
    @(negedge core_clk);
    wr_en = 1'b0;
    @(negedge core_clk);
  endtask : wr_reg
  // Second device faces the bench, so frames can break the rules on purpose
  task automatic send_b(input mrc_bytes_t q, input int stall);
    f = 3'h0;
    rx = {};
    foreach (q[i])
    begin
      while (link_b.m2d_ready !== 1'b1) @(negedge core_clk);
      link_b.m2d_valid = 1'b1;
      link_b.m2d_data = q[i];
      @(negedge core_clk);
    end
    link_b.m2d_valid = 1'b0;
    link_b.m2d_data = ~link_b.m2d_data;
    for (int k = 0; k < SIL + stall + 30; k++)
    begin
      link_b.d2m_ready = k >= stall;
      if (link_b.d2m_valid === 1'b1 && link_b.d2m_ready) rx.push_back(link_b.d2m_data);
      f = f | fb;
      @(negedge core_clk);
    end
  endtask : send_b
  task automatic cmp(input mrc_bytes_t got, input mrc_bytes_t exp);
    check(16'(got.size()), 16'(exp.size()));
    foreach (exp[i])
    begin
      if (i < got.size()) check(got[i], exp[i]);
    end
  endtask : cmp
  initial
  begin
    errors = 0;
    num_checks = 0;
    cyc = 0;
    oks = 0;
    reset_n = 1'b0;
    req_valid = 1'b0;
    req_addr = 8'h00;
    req_start = 16'h0000;
    req_count = 16'h0000;
    wr_en = 1'b0;
    wr_idx = 4'h0;
    wr_data = 16'h0000;
    rd_idx = 4'h0;
    link_b.m2d_valid = 1'b0;
    link_b.m2d_data = 8'h00;
    link_b.d2m_ready = 1'b0;
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge core_clk);
    check({req_ready, link.m2d_ready, link.d2m_valid}, 16'h0006);
    wr_reg(4'h2, 16'h1770);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h5, 16'h8001);
    wr_reg(4'he, 16'h5a3c);
    wr_reg(4'hf, 16'hffff);
    foreach (rows[i])
    begin
      n = 0;
      k0 = oks;
      while (req_ready !== 1'b1) @(negedge core_clk);
      req_valid = 1'b1;
      req_addr = rows[i].adr;
      req_start = rows[i].st;
      req_count = rows[i].cnt;
      @(negedge core_clk);
      req_valid = 1'b0;
      while (done !== 1'b1)
      begin
        @(negedge core_clk);
        if (rsp_valid === 1'b1)
        begin
          check(rsp_data, n == 0 ? rows[i].w0 : rows[i].w1);
          n++;
        end
      end
      check(m_err, 16'h0000);
      check(16'(n), rows[i].adr == 8'h00 ? 16'h0000 : rows[i].cnt);
      // A broadcast is done before the device has closed the frame on silence
      repeat (SIL + 4) @(negedge core_clk);
      check(16'(oks - k0), 16'h0001);
    end
    // Nine reply bytes against eight buffer words while the far side stalls
    send_b('{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02, 8'h6f, 8'hf7}, 40);
    check(f, 16'h0002);
    cmp(rx, '{8'h01, 8'h03, 8'h04, 8'h17, 8'h70, 8'h00, 8'h00, 8'hfe, 8'h5c});
    send_b('{8'h01, 8'h03, 8'h21, 8'h02, 8'h00, 8'h02, 8'h6f, 8'hf6}, 0);
    check(f, 16'h0004);
    check(16'(rx.size()), 16'h0000);
    fr = with_crc('{8'h01, 8'h06, 8'h00, 8'h07, 8'h12, 8'h34});
    send_b(fr, 0);
    check(f, 16'h0002);
    cmp(rx, fr);
    send_b(with_crc('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01}), 0);
    check({f[2], f[0]}, 16'h0001);
    send_b(with_crc('{8'h02, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}), 0);
    check(f, 16'h0000);
    send_b(with_crc('{8'h00, 8'h06, 8'h00, 8'h08, 8'hab, 8'hcd}), 0);
    check(16'(rx.size()), 16'h0000);
    rd_idx = 4'h7;
    repeat (2) @(negedge core_clk);
    check(rd_b, 16'h1234);
    rd_idx = 4'h8;
    repeat (2) @(negedge core_clk);
    check(rd_b, 16'habcd);
    check(rd_a, 16'h0000);
    results();
  end
endmodule : tb_top
`default_nettype wire
